// ---- logic/emdec_decoder.sv ----
// emdec_decoder: picks emulation memory, mcu internals or target system per address
// assumes config is stable while addresses flow; pins come from outside the clock
// a bad config drops every expansion hit; the fixed map keeps working meanwhile
// answers are registered, one cycle behind the address on the link
//
// Behaviour
// - at most four expansion areas held
// - area size 256 KB or 1 MB
// - 256 KB bank low digit 0/4/8/C
// - 1 MB bank low digit 0
// - host keeps total within 1.5 MB
// - only listed size mixes valid
// - host avoids overlapping areas
// - reserved range never from expansion memory
// - internal ROM auto-mapped in two modes
// - reset vector always from emulation memory
// - special function and RAM go internal
// - everything else goes external
// - report mode and handshake pin levels
// - expansion mode may apply around breaks
// - target holds wait/hold/nmi high
// - bank is address bits 23 to 16
// - internal maps to emem, others external
`timescale 1ns/100ps
module emdec_decoder #(
	parameter int AREAS = emdec_pkg::AREAS
) (
	input wire logic clk_in,
	input wire logic reset_in,
	emdec_if.device bus
);
	// named counts so no bare figure sits in the decode
	localparam logic [2:0] MAX_1M_AREAS = 3'h1;
	localparam logic [3:0] NO_UNITS = 4'h0;
	localparam logic [emdec_pkg::ADDR_W-1:0] ADDR_TOP = '1;

	// bank match for one area under its size mask; comparing two areas with the
	// wider of their masks makes a 1 MB area catch any 256 KB bank inside it
	function automatic logic area_hit(input logic [7:0] bank, input logic [7:0] abank,
		input logic is_1m);
		logic [7:0] m;
		m = is_1m ? emdec_pkg::MASK_1M : emdec_pkg::MASK_256K;
		area_hit = (bank & m) == (abank & m);
	endfunction

	// low bank bits that must be clear for the chosen size
	function automatic logic bank_misaligned(input logic [7:0] abank, input logic is_1m);
		logic [7:0] free;
		free = is_1m ? emdec_pkg::ALIGN_1M : emdec_pkg::ALIGN_256K;
		bank_misaligned = (abank & free) != 8'h00;
	endfunction

	// inclusive window test shared by every fixed region
	function automatic logic in_window(input logic [emdec_pkg::ADDR_W-1:0] a,
		input logic [emdec_pkg::ADDR_W-1:0] lo, input logic [emdec_pkg::ADDR_W-1:0] hi);
		in_window = (a >= lo) && (a <= hi);
	endfunction

	// size of one area in 256 KB units, zero when the area is unused
	function automatic logic [3:0] area_units(input logic is_used, input logic is_1m);
		if (!is_used)
			area_units = NO_UNITS;
		else if (is_1m)
			area_units = emdec_pkg::UNITS_1M;
		else
			area_units = emdec_pkg::UNITS_256K;
	endfunction

	wire logic [7:0] bank = bus.addr[emdec_pkg::ADDR_W-1:emdec_pkg::BANK_LSB];
	wire logic [AREAS-1:0] used;
	wire logic [AREAS-1:0] misalign;
	wire logic [AREAS-1:0] emem_hit;
	wire logic [AREAS-1:0][3:0] units;
	wire logic [AREAS-1:0][AREAS-1:0] overlap;

	// per-area checks and matches
	genvar i, j;
	generate
		for (i = 0; i < AREAS; i++) begin : g_area
			assign used[i] = bus.area_map[i] != emdec_pkg::EMDEC_UNUSED;
			// an unused area may hold any bank without being flagged
			assign misalign[i] = used[i] &&
				bank_misaligned(bus.area_bank[i], bus.area_1m[i]);
			// size kept as a small unit count so the sum stays narrow
			assign units[i] = area_units(used[i], bus.area_1m[i]);
			assign emem_hit[i] = bus.area_map[i] == emdec_pkg::EMDEC_INTERNAL &&
				!misalign[i] && area_hit(bank, bus.area_bank[i], bus.area_1m[i]);
			for (j = 0; j < AREAS; j++) begin : g_pair
				assign overlap[i][j] = (j > i) && used[i] && used[j] &&
					area_hit(bus.area_bank[i], bus.area_bank[j],
						bus.area_1m[i] | bus.area_1m[j]);
			end
		end
	endgenerate

	// size-mix and total: summed units fit, and at most one 1 MB area
	logic [5:0] total;
	logic [2:0] n_1m;
	always_comb begin
		total = '0;
		n_1m = '0;
		for (int k = 0; k < AREAS; k++) begin
			total = total + 6'(units[k]);
			n_1m = n_1m + 3'(used[k] && bus.area_1m[k]);
		end
	end
	// 1 MB plus two 256 KB is the largest legal mix; a 256 KB-only set may reach four
	wire logic too_many_1m = n_1m > MAX_1M_AREAS;
	wire logic over_total = total > 6'(emdec_pkg::EMEM_UNITS);
	wire logic mix_bad = too_many_1m || (n_1m == MAX_1M_AREAS && over_total);
	// single-chip mode has no expansion memory, so any used area there is a fault
	wire logic expand_in_single = bus.mode == emdec_pkg::EMDEC_SINGLE && (|used);
	wire logic any_misalign = |misalign;
	wire logic any_overlap = |overlap;
	// one flag for all faults; the host sees it and the area hits are dropped,
	// trading a lost mapping for never aliasing two areas onto one memory
	wire logic cfg_bad = any_misalign || mix_bad || any_overlap || expand_in_single;

	// fixed regions; each is a plain window so the map can move with the package
	// the vector and rom windows both run to the top of the address space
	wire logic in_iram = in_window(bus.addr, emdec_pkg::IRAM_LO,
		emdec_pkg::IRAM_HI);
	wire logic in_rsv = in_window(bus.addr, emdec_pkg::RSV_LO,
		emdec_pkg::RSV_HI);
	wire logic in_vec = in_window(bus.addr, emdec_pkg::VEC_LO, ADDR_TOP);
	wire logic in_irom = in_window(bus.addr, emdec_pkg::IROM_LO, ADDR_TOP);
	// expansion mode may be in force even when software leaves single-chip later
	wire logic rom_auto = bus.mode != emdec_pkg::EMDEC_MICRO && in_irom;
	// bad config blocks every expansion hit rather than aliasing memory
	wire logic area_emem = (|emem_hit) && !cfg_bad &&
		bus.mode != emdec_pkg::EMDEC_SINGLE;

	// priority: internals, reserved, vector, rom, then areas, then external;
	// the fixed classes are resolved first so no area setting can reach them
	wire logic to_mcu = in_iram || in_rsv;
	wire logic to_emem_fixed = in_vec || rom_auto;
	wire logic to_emem = to_emem_fixed || area_emem;
	emdec_pkg::emdec_tgt_t tgt_d;
	assign tgt_d = to_mcu ? emdec_pkg::EMDEC_T_MCU :
		to_emem ? emdec_pkg::EMDEC_T_EMEM :
		emdec_pkg::EMDEC_T_EXT;

	// registered decision, one cycle after the address; the target follows every
	// cycle and valid alone says whether it counts
	emdec_pkg::emdec_tgt_t tgt_q;
	logic tv_q;
	logic err_q;
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			tgt_q <= emdec_pkg::EMDEC_T_EXT;
		end else begin
			tgt_q <= tgt_d;
		end
	end
	// valid runs beside the target, one stage late
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			tv_q <= 1'b0;
		end else begin
			tv_q <= bus.addr_valid;
		end
	end
	// config fault as a level; follows the settings with one cycle of lag
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			err_q <= 1'b0;
		end else begin
			err_q <= cfg_bad;
		end
	end

	// pin readback, three-stage sync per pin; a change is taken only when stages
	// two and three agree, so a level caught mid-transition never reaches the host
	// reset value is high, the idle level of every handshake pin
	wire logic [emdec_pkg::PIN_W-1:0] pin_lvl;
	genvar p;
	generate
		for (p = 0; p < emdec_pkg::PIN_W; p++) begin : g_pin
			logic s1_q, s2_q, s3_q, lvl_q;
			wire logic settled = s2_q == s3_q;
			// sync stages; only the second stage reads the first
			always_ff @(posedge clk_in) begin
				if (reset_in) begin
					s1_q <= 1'b1;
					s2_q <= 1'b1;
					s3_q <= 1'b1;
				end else begin
					s1_q <= bus.pins[p];
					s2_q <= s1_q;
					s3_q <= s2_q;
				end
			end

			// filter stage: holds the last agreed level
			always_ff @(posedge clk_in) begin
				if (reset_in) begin
					lvl_q <= 1'b1;
				end else if (settled) begin
					lvl_q <= s3_q;
				end
			end
			assign pin_lvl[p] = lvl_q;
		end
	endgenerate

	assign bus.target = tgt_q;
	assign bus.target_valid = tv_q;
	assign bus.cfg_error = err_q;
	assign bus.pin_status = pin_lvl; // low wait/hold/nmi visible here
endmodule

// ---- pkg/emdec_pkg.sv ----
// emdec_pkg: shared constants and types for the emulation memory map decoder
// assumes a 24-bit byte address bus and up to four expansion areas
package emdec_pkg;
	localparam int ADDR_W = 24;
	localparam int BANK_W = 8;
	localparam int AREAS = 4;
	// bank gives address bits 23..16
	localparam int BANK_LSB = 16;
	// 256 KB area: bank low bits [1:0] free; 1 MB area: bank low bits [3:0] free
	localparam logic [7:0] MASK_256K = 8'hFC;
	localparam logic [7:0] MASK_1M = 8'hF0;
	localparam logic [7:0] ALIGN_256K = 8'h03;
	localparam logic [7:0] ALIGN_1M = 8'h0F;
	// total emulation memory in 256 KB units (1.5 MB)
	localparam logic [3:0] EMEM_UNITS = 4'h6;
	localparam logic [3:0] UNITS_256K = 4'h1;
	localparam logic [3:0] UNITS_1M = 4'h4;
	// fixed map
	localparam logic [23:0] RSV_LO = 24'h006400;
	localparam logic [23:0] RSV_HI = 24'h007FFF;
	localparam logic [23:0] IRAM_LO = 24'h000000;
	localparam logic [23:0] IRAM_HI = 24'h0063FF;
	localparam logic [23:0] IROM_LO = 24'hFC0000;
	localparam logic [23:0] VEC_LO = 24'hFFFFDC;
	typedef enum logic [1:0] {EMDEC_SINGLE, EMDEC_EXPAND, EMDEC_MICRO} emdec_mode_t;
	typedef enum logic [1:0] {EMDEC_UNUSED, EMDEC_INTERNAL, EMDEC_EXTERNAL} emdec_map_t;
	typedef enum logic [1:0] {EMDEC_T_EXT, EMDEC_T_EMEM, EMDEC_T_MCU} emdec_tgt_t;
	// pin status word bit positions
	localparam int PIN_BYTE = 0;
	localparam int PIN_MODE = 1;
	localparam int PIN_WAIT = 2;
	localparam int PIN_HOLD = 3;
	localparam int PIN_NMI = 4;
	localparam int PIN_W = 5;
endpackage

// ---- pkg/emdec_if.sv ----
// emdec_if: joins the decoder (device end) with the bus/config source (host end)
// assumes one clock shared by both ends
`timescale 1ns/100ps
interface emdec_if;
	logic [emdec_pkg::ADDR_W-1:0] addr;
	logic addr_valid;
	emdec_pkg::emdec_mode_t mode;
	logic [emdec_pkg::AREAS-1:0][emdec_pkg::BANK_W-1:0] area_bank;
	logic [emdec_pkg::AREAS-1:0] area_1m;
	emdec_pkg::emdec_map_t [emdec_pkg::AREAS-1:0] area_map;
	logic [emdec_pkg::PIN_W-1:0] pins;
	emdec_pkg::emdec_tgt_t target;
	logic target_valid;
	logic cfg_error;
	logic [emdec_pkg::PIN_W-1:0] pin_status;
	modport device (input addr, addr_valid, mode, area_bank, area_1m, area_map, pins,
		output target, target_valid, cfg_error, pin_status);
	modport host (output addr, addr_valid, mode, area_bank, area_1m, area_map, pins,
		input target, target_valid, cfg_error, pin_status);
endinterface

// ---- logic/emdec_host.sv ----
// emdec_host: the mcu bus and debugger side; registers config and issues addresses
// assumes user side holds config steady while it presents addresses
//
// Behaviour
// host keeps alignment, size mix, total and non-overlap legal; this module registers the config unchecked
`timescale 1ns/100ps
module emdec_host (
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic [23:0] addr_in,
	input wire logic addr_valid_in,
	input wire logic [1:0] mode_in,
	input wire logic [31:0] area_bank_in,
	input wire logic [3:0] area_1m_in,
	input wire logic [7:0] area_map_in,
	input wire logic [4:0] pins_in,
	output logic [1:0] target_out,
	output logic target_valid_out,
	output logic cfg_error_out,
	output logic [4:0] pin_status_out,
	emdec_if.host bus
);
	// drive link from flops, pins straight from pins_in; user is responsible
	logic [23:0] addr_q;
	logic av_q;
	logic [1:0] mode_q;
	logic [31:0] bank_q;
	logic [3:0] m1_q;
	logic [7:0] map_q;
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			addr_q <= '0;
			av_q <= 1'b0;
			mode_q <= 2'h0;
			bank_q <= '0;
			m1_q <= '0;
			map_q <= '0;
		end else begin
			addr_q <= addr_in;
			av_q <= addr_valid_in;
			mode_q <= mode_in;
			bank_q <= area_bank_in;
			m1_q <= area_1m_in;
			map_q <= area_map_in;
		end
	end
	assign bus.addr = addr_q;
	assign bus.addr_valid = av_q;
	assign bus.mode = emdec_pkg::emdec_mode_t'(mode_q);
	assign bus.area_bank = bank_q;
	assign bus.area_1m = m1_q;
	// bit-stream cast: one enum field per area, two bits each
	typedef emdec_pkg::emdec_map_t [emdec_pkg::AREAS-1:0] emdec_map_vec_t;
	assign bus.area_map = emdec_map_vec_t'(map_q);
	assign bus.pins = pins_in;
	// answers back to user, registered
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			target_out <= 2'h0;
			target_valid_out <= 1'b0;
			cfg_error_out <= 1'b0;
			pin_status_out <= '1;
		end else begin
			target_out <= bus.target;
			target_valid_out <= bus.target_valid;
			cfg_error_out <= bus.cfg_error;
			pin_status_out <= bus.pin_status;
		end
	end
endmodule

// ---- sim/emdec_checker.sv ----
// emdec_checker: timing checks on the decoder side of emdec_if
// assumes one clock, sync active-high reset, config steady between changes
`timescale 1ns/100ps
module emdec_checker (
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic [23:0] addr,
	input wire logic addr_valid,
	input wire emdec_pkg::emdec_mode_t mode,
	input wire logic [3:0][7:0] area_bank,
	input wire logic [3:0] area_1m,
	input wire emdec_pkg::emdec_map_t [3:0] area_map,
	input wire logic [4:0] pins,
	input wire emdec_pkg::emdec_tgt_t target,
	input wire logic target_valid,
	input wire logic cfg_error,
	input wire logic [4:0] pin_status
);
	// single domain, so clock and reset are given once
	default clocking @(posedge clk_in); endclocking
	default disable iff (reset_in);
	a_valid_one_cycle: assert property (1 |=> target_valid == $past(addr_valid))
		else $error("valid not one cycle late");
	a_low_to_mcu: assert property (addr <= 24'h007FFF |=> target == emdec_pkg::EMDEC_T_MCU)
		else $error("low space not internal");
	a_vector_emem: assert property (addr >= 24'hFFFFDC |=> target == emdec_pkg::EMDEC_T_EMEM)
		else $error("vector not emem");
	a_rom_auto: assert property (addr >= 24'hFC0000 && mode != emdec_pkg::EMDEC_MICRO
		|=> target == emdec_pkg::EMDEC_T_EMEM) else $error("rom not emem");
	a_single_ext: assert property (mode == emdec_pkg::EMDEC_SINGLE && addr >= 24'h008000
		&& addr < 24'hFC0000 |=> target == emdec_pkg::EMDEC_T_EXT) else $error("single not ext");
	// pin levels settle within six quiet edges
	a_pin_echo: assert property ($stable(pins) [*6] |-> pin_status == pins)
		else $error("pin status stale");
	a_bad_1m: assert property (area_map[0] != 0 && area_1m[0] && area_bank[0][3:0] != 4'h0
		|=> cfg_error) else $error("1m misalign missed");
	a_bad_256k: assert property (area_map[0] != 0 && !area_1m[0] && area_bank[0][1:0] != 2'h0
		|=> cfg_error) else $error("256k misalign missed");
endmodule

// ---- sim/emulation_memory_map_decoder_tb.sv ----
// emulation_memory_map_decoder_tb: both ends joined, corner and random maps swept
// assumes target_out lags addr_in by 3 edges and pins settle within 5
`timescale 1ns/100ps
module emulation_memory_map_decoder_tb;
	localparam logic [23:0] CORNER[9] = '{24'h0063FF, 24'h006400, 24'h007FFF, 24'h008000,
		24'hFBFFFF, 24'hFC0000, 24'hFFFFDB, 24'hFFFFDC, 24'h0FFFFF};
	logic clk_in = 0, reset_in = 1, addr_valid_in = 0, target_valid_out, cfg_error_out;
	logic [23:0] addr_in = 0;
	logic [1:0] md = 1, target_out, ex[24];
	logic [31:0] bk = 0;
	logic [3:0] big = 0;
	logic [7:0] mp = 0;
	logic [4:0] pins_in = 5'h1F, pin_status_out;
	logic vx[24];
	int err_count = 0, checked = 0;
	emdec_if bus_if();
	emdec_decoder emdec_decoder_i(.clk_in(clk_in), .reset_in(reset_in), .bus(bus_if));
	emdec_host emdec_host_i(.clk_in(clk_in), .reset_in(reset_in), .addr_in(addr_in),
		.addr_valid_in(addr_valid_in), .mode_in(md), .area_bank_in(bk), .area_1m_in(big),
		.area_map_in(mp), .pins_in(pins_in), .target_out(target_out),
		.target_valid_out(target_valid_out), .cfg_error_out(cfg_error_out),
		.pin_status_out(pin_status_out), .bus(bus_if));
	emdec_checker emdec_checker_i(.clk_in(clk_in), .reset_in(reset_in), .addr(bus_if.addr),
		.addr_valid(bus_if.addr_valid), .mode(bus_if.mode), .area_bank(bus_if.area_bank),
		.area_1m(bus_if.area_1m), .area_map(bus_if.area_map), .pins(bus_if.pins),
		.target(bus_if.target), .target_valid(bus_if.target_valid),
		.cfg_error(bus_if.cfg_error), .pin_status(bus_if.pin_status));
	// 100 ns clock
	initial forever #50 clk_in = ~clk_in;
	// misalign, size mix, total, overlap, or areas in single-chip mode
	function automatic logic bad();
		int u = 0, m = 0, b[4], s[4];
		bad = (0);
		for (int i = 0; i < 4; i++) begin
			b[i] = bk[8*i+:8];
			s[i] = big[i] ? 16 : 4;
			if (mp[2*i+:2] != 0) begin
				u += s[i] / 4;
				m += big[i];
				if (b[i] % s[i] != 0 || md == 0) bad = 1;
				for (int j = 0; j < i; j++)
					if (mp[2*j+:2] != 0 && b[i] < b[j] + s[j] && b[j] < b[i] + s[i]) bad = 1;
			end
		end
		if (u > 6 || m > 1) bad = 1;
	endfunction
	// fixed maps first, then internal area hits
	function automatic logic [1:0] exp_tgt(logic [23:0] a);
		logic h = 0;
		for (int i = 0; i < 4; i++)
			if (mp[2*i+:2] == 1 && a[23:16] >= bk[8*i+:8] && a[23:16] < bk[8*i+:8] + (big[i] ? 16 : 4))
				h = 1;
		if (a <= 24'h007FFF) return emdec_pkg::EMDEC_T_MCU;
		if (a >= 24'hFFFFDC || (a >= 24'hFC0000 && md != 2)) return emdec_pkg::EMDEC_T_EMEM;
		return (h && !bad()) ? emdec_pkg::EMDEC_T_EMEM : emdec_pkg::EMDEC_T_EXT;
	endfunction
	task automatic cmp(string n, logic [4:0] e, logic [4:0] s);
		checked++;
		if (s !== e) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// three fixed maps (good, single-chip, misaligned 1 MB) then random ones
	initial begin
		logic [23:0] a;
		void'($urandom(47148));
		repeat (20) @(negedge clk_in);
		reset_in = 0;
		for (int k = 0; k < 40; k++) begin
			@(negedge clk_in);
			bk = 32'h00A86400 | ((k == 2) ? 32'h2 : 32'h0);
			big = 4'h1;
			mp = 8'h15;
			md = (k == 1) ? 2'h0 : 2'h1;
			for (int i = 0; i < 4 && k > 2; i++) begin
				big[i] = ($urandom % 5 == 0);
				bk[8*i+:8] = 8'($urandom) & (($urandom % 4 == 0) ? 8'hFF : big[i] ? 8'hF0 : 8'hFC);
				mp[2*i+:2] = 2'($urandom % 3);
				md = 2'($urandom % 3);
			end
			pins_in = 5'($urandom);
			repeat (4) @(negedge clk_in);
			cmp("cfg_error", {4'h0, bad()}, {4'h0, cfg_error_out});
			for (int i = 0; i < 27; i++) begin
				@(negedge clk_in);
				if (i > 2 && vx[i-3]) cmp("target", {3'h0, ex[i-3]}, {3'h0, target_out});
				if (i > 2) cmp("valid", {4'h0, vx[i-3]}, {4'h0, target_valid_out});
				if (i < 24) begin
					a = {bk[8*($urandom%4)+:8] + 8'($urandom % 16), 16'($urandom)};
					if (i < 9) a = CORNER[i];
					else if ($urandom % 2) a = 24'($urandom);
					addr_in = a;
					addr_valid_in = 1'($urandom);
					ex[i] = exp_tgt(a);
					vx[i] = addr_valid_in;
				end
			end
			cmp("pin_status", pins_in, pin_status_out);
			$display("trial %0d done", k);
		end
		wrap_up();
	end
endmodule
